/* rtl/ecwf_pkg.sv */
// Constants and types for the event capture and wake flagging block.
package ecwf_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the serial register port
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_SYS_EN     = 7'h04;
  localparam logic [6:0] ADDR_TRX_EN     = 7'h23;
  localparam logic [6:0] ADDR_WAKE_EN    = 7'h4C;
  localparam logic [6:0] ADDR_SUMMARY    = 7'h60;
  localparam logic [6:0] ADDR_SYS_FLAGS  = 7'h61;
  localparam logic [6:0] ADDR_TRX_FLAGS  = 7'h63;
  localparam logic [6:0] ADDR_WAKE_FLAGS = 7'h64;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SYS_PO     = 4;  // Battery restore flag.
  localparam int SYS_OTW    = 2;  // Overtemperature warning.
  localparam int SYS_SF     = 1;  // Serial port fault.
  localparam int TRX_FE     = 5;  // Selective frame error.
  localparam int TRX_SIL    = 4;  // Bus silence.
  localparam int TRX_FAIL   = 1;  // Bus failure.
  localparam int TRX_WAKE   = 0;  // Bus wake.
  localparam int WAKE_RISE  = 1;  // Wake pin rising edge.
  localparam int WAKE_FALL  = 0;  // Wake pin falling edge.
  localparam int SUM_WAKE   = 3;  // Summary: wake pin pending.
  localparam int SUM_TRX    = 2;  // Summary: transceiver pending.
  localparam int SUM_SYS    = 0;  // Summary: system pending.

  // Implemented bits of each register; reserved bits read as zero.
  localparam logic [7:0] SYS_FLAG_MASK  = 8'h16;
  localparam logic [7:0] TRX_FLAG_MASK  = 8'h33;
  localparam logic [7:0] WAKE_FLAG_MASK = 8'h03;
  localparam logic [7:0] SYS_EN_MASK    = 8'h06;
  localparam logic [7:0] TRX_EN_MASK    = 8'h13;
  localparam logic [7:0] WAKE_EN_MASK   = 8'h03;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // Command codes and reset levels
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SLEEP_CMD = 3'h1;
  localparam logic [1:0] CMC_UV_CHECK   = 2'h1;
  localparam logic       SUPPLY_RESET   = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_SYS_PERIOD_NS  = 5;
  localparam int SILENCE_TIMEOUT_US = 1000;  // Plain default.
  localparam int CNT_W              = 24;

  // Synchronised input positions.
  localparam int SYN_WAKE  = 0;
  localparam int SYN_OTP   = 1;
  localparam int SYN_TXD   = 2;
  localparam int SYN_UV    = 3;
  localparam int SYN_BUS   = 4;
  localparam int SYN_WTOG  = 5;
  localparam int SYN_FTOG  = 6;
  localparam int SYN_N     = 7;

  // Delay timer states, one-hot.
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN  = 2'b10
  } ecwf_tmr_e;

  // All state of the system clock domain.
  typedef struct packed {
    logic [SYN_N-1:0] s1;
    logic [SYN_N-1:0] s2;
    logic [SYN_N-1:0] s3;
    logic [SYN_N-1:0] flt;
    logic [7:0]       sys_en;
    logic [7:0]       trx_en;
    logic [7:0]       wake_en;
    logic [7:0]       sys_fl;
    logic [7:0]       trx_fl;
    logic [7:0]       wake_fl;
    logic [7:0]       rdata;
    ecwf_tmr_e        tst;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] sil;
    logic             rxd_hi;
    logic             supply;
    logic             to_stby;
    logic             slp_ok;
    logic             slp_ref;
  } ecwf_sys_s;

  // All state of the link clock domain.
  typedef struct packed {
    logic [1:0] rst_sync;
    logic       tog_wake;
    logic       tog_ferr;
  } ecwf_link_s;

endpackage

/* rtl/ecwf_event_capture.sv */
// Event capture, flag registers, event delay timer and sleep guard.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module ecwf_event_capture
  import ecwf_pkg::*;
#(
  parameter logic [CNT_W-1:0] EVENT_DELAY_CYC = 24'h0007D0,
  parameter logic [CNT_W-1:0] SILENCE_CYC =
    CNT_W'(SILENCE_TIMEOUT_US * 1000 / CLK_SYS_PERIOD_NS)
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_link,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       serial_fault_evt,
  input  wire logic       por_evt,
  input  wire logic       uv_forced_sleep,
  input  wire logic       mode_cmd_valid,
  input  wire logic [2:0] mode_command_field,
  input  wire logic       mode_is_sleep,
  input  wire logic       mode_is_normal,
  input  wire logic       trx_active,
  input  wire logic       trx_offline,
  input  wire logic [1:0] bus_mode_control_field,
  input  wire logic       wake_pin,
  input  wire logic       overtemp_pin,
  input  wire logic       txd_clamp_pin,
  input  wire logic       vcc_uv_pin,
  input  wire logic       bus_activity_pin,
  input  wire logic       link_bus_wake,
  input  wire logic       link_frame_err,
  output logic            rxd_out,
  output logic            supply_enable_output,
  output logic            wake_to_standby,
  output logic            sleep_grant,
  output logic            sleep_refused
);

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  ecwf_link_s lq;  // Registered link state.
  ecwf_link_s ld;  // Next link state.

  // Each link event flips a toggle; the system side sees the change.
  // A toggle survives a stopped link clock, a pulse would not.
  // Reset reaches the link side through two stages of its own.
  always_comb begin
    ld          = lq;
    ld.rst_sync = {lq.rst_sync[0], !reset};
    ld.tog_wake = lq.tog_wake ^ link_bus_wake;
    ld.tog_ferr = lq.tog_ferr ^ link_frame_err;
    if (!lq.rst_sync[1]) begin
      ld.tog_wake = 1'b0;
      ld.tog_ferr = 1'b0;
    end
  end

  // Register the link state on every rising link clock edge.
  always_ff @(posedge clk_link) begin
    lq <= ld;
  end

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  ecwf_sys_s        q;          // Registered state.
  ecwf_sys_s        d;          // Next state.
  logic [SYN_N-1:0] pins;       // Raw asynchronous inputs.
  logic [SYN_N-1:0] rise;       // Filtered rising edges.
  logic [SYN_N-1:0] fall;       // Filtered falling edges.
  logic [SYN_N-1:0] chg;        // Filtered changes.
  logic [7:0]       set_sys, set_trx, set_wake;  // Hardware sets.
  logic [7:0]       clr_sys, clr_trx, clr_wake;  // Software clears.
  logic [7:0]       summary;    // Global summary value.
  logic             clr_any;    // A set flag is being cleared.
  logic             pend_q;     // Any flag set now.
  logic             pend_d;     // Any flag set next cycle.
  logic             sleep_cmd;  // Go-to-sleep command seen.
  logic             wake_src;   // Some regular wake source on.
  logic             sil_hit;    // Silence count just expired.
  logic             wake_evt;   // Event that ends sleep.

  assign pins = {lq.tog_ferr, lq.tog_wake, bus_activity_pin,
                 vcc_uv_pin, txd_clamp_pin, overtemp_pin, wake_pin};

  // Next state of the whole capture block.
  always_comb begin
    d = q;
    // Three stages; a level counts once stages two and three agree.
    d.s1  = pins;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
    rise  = d.flt & ~q.flt;
    fall  = ~d.flt & q.flt;
    chg   = d.flt ^ q.flt;

    // Silence counter restarts on every bus activity change.
    sil_hit = 1'b0;
    if (chg[SYN_BUS]) begin
      d.sil = '0;
    end else if (q.sil != SILENCE_CYC) begin
      d.sil   = q.sil + 1'b1;
      sil_hit = (d.sil == SILENCE_CYC);
    end

    // Restore and frame error need no enable.
    set_sys          = '0;
    set_sys[SYS_PO]  = por_evt;
    set_sys[SYS_OTW] = rise[SYN_OTP] & mode_is_normal
                       & q.sys_en[SYS_OTW];
    set_sys[SYS_SF]  = serial_fault_evt & q.sys_en[SYS_SF];
    set_trx          = '0;
    set_trx[TRX_FE]  = chg[SYN_FTOG];
    set_trx[TRX_SIL] = sil_hit & q.trx_en[TRX_SIL];
    // Failure only while Normal and active.
    set_trx[TRX_FAIL] = q.trx_en[TRX_FAIL] & mode_is_normal
      & trx_active & (rise[SYN_TXD]
      | (rise[SYN_UV] & (bus_mode_control_field == CMC_UV_CHECK)));
    set_trx[TRX_WAKE] = chg[SYN_WTOG] & trx_offline
                        & q.trx_en[TRX_WAKE];
    set_wake            = '0;
    set_wake[WAKE_RISE] = rise[SYN_WAKE] & q.wake_en[WAKE_RISE];
    set_wake[WAKE_FALL] = fall[SYN_WAKE] & q.wake_en[WAKE_FALL];

    // Write one clears; masks keep reserved bits zero.
    clr_sys  = '0;
    clr_trx  = '0;
    clr_wake = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SYS_FLAGS:  clr_sys  = reg_wdata & SYS_FLAG_MASK;
        ADDR_TRX_FLAGS:  clr_trx  = reg_wdata & TRX_FLAG_MASK;
        ADDR_WAKE_FLAGS: clr_wake = reg_wdata & WAKE_FLAG_MASK;
        ADDR_SYS_EN:     d.sys_en  = reg_wdata & SYS_EN_MASK;
        ADDR_TRX_EN:     d.trx_en  = reg_wdata & TRX_EN_MASK;
        ADDR_WAKE_EN:    d.wake_en = reg_wdata & WAKE_EN_MASK;
        // The summary is read only; other addresses are ignored.
        default:         d.sys_en  = q.sys_en;
      endcase
    end
    clr_any = |((q.sys_fl & clr_sys) | (q.trx_fl & clr_trx)
                | (q.wake_fl & clr_wake));

    // Sets land even while the timer runs; set beats clear.
    d.sys_fl  = (q.sys_fl & ~clr_sys) | set_sys;
    d.trx_fl  = (q.trx_fl & ~clr_trx) | set_trx;
    d.wake_fl = (q.wake_fl & ~clr_wake) | set_wake;

    // Forced sleep wipes all flags, restore flag included.
    // Wake sources are forced on so the part can still wake.
    if (uv_forced_sleep) begin
      d.sys_fl  = REG_RESET;
      d.trx_fl  = REG_RESET;
      d.wake_fl = REG_RESET;
      d.trx_en[TRX_WAKE]   = 1'b1;
      d.wake_en[WAKE_RISE] = 1'b1;
      d.wake_en[WAKE_FALL] = 1'b1;
    end
    pend_q = |{q.sys_fl, q.trx_fl, q.wake_fl};
    pend_d = |{d.sys_fl, d.trx_fl, d.wake_fl};

    // Delay timer; a clear in the idle or run state loads the full delay.
    case (q.tst)
      TMR_IDLE: begin
        if (clr_any) begin
          d.tst = TMR_RUN;
          d.tmr = EVENT_DELAY_CYC;
        end
      end
      TMR_RUN: begin
        // A further clear restarts the delay.
        if (clr_any) begin
          d.tmr = EVENT_DELAY_CYC;
        end else if (q.tmr <= 1) begin
          d.tst = TMR_IDLE;
          d.tmr = '0;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      default: begin
        d.tst = TMR_IDLE;
        d.tmr = '0;
      end
    endcase

    // Offline pending events pull the pin low.
    // Expiry with pending flags alerts again.
    // With nothing pending the pin stays high.
    d.rxd_hi = !(trx_offline && pend_d && d.tst == TMR_IDLE);

    // Sleep needs a wake source and no pending flag.
    sleep_cmd = mode_cmd_valid
                && (mode_command_field == MODE_SLEEP_CMD);
    wake_src  = q.trx_en[TRX_WAKE] | q.wake_en[WAKE_RISE]
                | q.wake_en[WAKE_FALL];
    d.slp_ok  = sleep_cmd && wake_src && !pend_q;
    d.slp_ref = sleep_cmd && !(wake_src && !pend_q);

    // Any event but a serial fault ends sleep.
    wake_evt  = mode_is_sleep && (|set_trx || |set_wake
                || set_sys[SYS_PO] || set_sys[SYS_OTW]);
    d.to_stby = wake_evt;
    if (wake_evt) begin
      d.supply = 1'b1;
    end else if (d.slp_ok) begin
      d.supply = 1'b0;
    end

    // Summary built from the flag registers.
    summary           = '0;
    summary[SUM_WAKE] = |q.wake_fl;
    summary[SUM_TRX]  = |q.trx_fl;
    summary[SUM_SYS]  = |q.sys_fl;

    // Reads only sample; they change no flag.
    // Flag layouts come out as stored.
    d.rdata = REG_RESET;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SYS_EN:     d.rdata = q.sys_en;
        ADDR_TRX_EN:     d.rdata = q.trx_en;
        ADDR_WAKE_EN:    d.rdata = q.wake_en;
        ADDR_SUMMARY:    d.rdata = summary;
        ADDR_SYS_FLAGS:  d.rdata = q.sys_fl;
        ADDR_TRX_FLAGS:  d.rdata = q.trx_fl;
        ADDR_WAKE_FLAGS: d.rdata = q.wake_fl;
        default:         d.rdata = REG_RESET;
      endcase
    end
  end

  // Register the state; reset clears all but timer state, pin and supply.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q        <= '0;
      q.tst    <= TMR_IDLE;
      q.rxd_hi <= 1'b1;
      q.supply <= SUPPLY_RESET;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata            = q.rdata;
  assign rxd_out              = q.rxd_hi;
  assign supply_enable_output = q.supply;
  assign wake_to_standby      = q.to_stby;
  assign sleep_grant          = q.slp_ok;
  assign sleep_refused        = q.slp_ref;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // A clear followed by two quiet cycles of released pin.
  sequence s_clear;
    clr_any && !uv_forced_sleep;
  endsequence
  sequence s_released;
    (rxd_out && q.tst == TMR_RUN) [*2];
  endsequence

  // Releasing the pin holds through the start of the delay.
  chk_clear_release: assert property (
    s_clear |=> s_released)
    else $error("pin not released after a clear");

  // The running timer never lets the pin go low.
  chk_timer_high: assert property (
    q.tst == TMR_RUN |-> rxd_out)
    else $error("pin low while delay runs");

  // Expiry with a pending flag in offline pulls the pin low.
  chk_expiry_alert: assert property (
    q.tst == TMR_RUN && q.tmr == 1 && !clr_any && trx_offline
      && pend_d |=> !rxd_out)
    else $error("no alert at timer expiry");

  // A low pin always has a flag behind it.
  chk_empty_high: assert property (
    !rxd_out |-> pend_q)
    else $error("pin low with nothing pending");

  // A pure read leaves every flag as it was.
  chk_read_pure: assert property (
    reg_rd && !reg_wr && !uv_forced_sleep
      && !(|{set_sys, set_trx, set_wake})
      |=> $stable({q.sys_fl, q.trx_fl, q.wake_fl}))
    else $error("read changed a flag");

  // A sleep command without both conditions is refused.
  chk_sleep_guard: assert property (
    sleep_cmd && !(wake_src && !pend_q)
      |=> sleep_refused && !sleep_grant)
    else $error("sleep granted against the guard");

  // Writing one clears a fault flag unless a new event lands.
  chk_w1c_clear: assert property (
    reg_wr && reg_addr == ADDR_SYS_FLAGS && reg_wdata[SYS_SF]
      && !set_sys[SYS_SF] |=> !q.sys_fl[SYS_SF])
    else $error("write one did not clear");

  // The summary read matches the transceiver and wake flags of the cycle before.
  chk_summary_read: assert property (
    reg_rd && reg_addr == ADDR_SUMMARY
      |=> reg_rdata[SUM_TRX] == (|$past(q.trx_fl))
        && reg_rdata[SUM_WAKE] == (|$past(q.wake_fl)))
    else $error("summary does not match flags");

  // Forced sleep leaves the restore flag clear.
  chk_uv_clear: assert property (
    uv_forced_sleep |=> !q.sys_fl[SYS_PO])
    else $error("restore flag survived forced sleep");

  // A disabled source cannot raise its flag.
  chk_enable_gate: assert property (
    !q.sys_en[SYS_OTW] && !q.sys_fl[SYS_OTW]
      |=> !q.sys_fl[SYS_OTW])
    else $error("disabled overtemperature captured");

  // Wake from sleep raises supply and signals standby together.
  chk_sleep_wake: assert property (
    wake_evt |=> supply_enable_output && wake_to_standby)
    else $error("sleep wake missing outputs");

endmodule

/* tb/ecwf_link_model.sv */
// Link-side partner: makes the link clock and one-cycle link pulses.
`timescale 1ns/10ps
module ecwf_link_model (
  output logic clk_link,
  output logic link_bus_wake,
  output logic link_frame_err
);
  // ----------------------------------------------------------------
  // Link clock stands low between frames
  // ----------------------------------------------------------------
  initial begin
    clk_link       = 1'b0;
    link_bus_wake  = 1'b0;
    link_frame_err = 1'b0;
  end

  // One 80 ns link period.
  task automatic tick();
    #40 clk_link = 1'b1;
    #40 clk_link = 1'b0;
  endtask

  // One frame: a pulse held for a whole link cycle, then two idle
  // cycles so that a following pulse cannot merge with this one.
  task automatic send(input logic is_err);
    #13;
    tick();
    if (is_err) begin
      link_frame_err = 1'b1;
    end else begin
      link_bus_wake = 1'b1;
    end
    tick();
    link_frame_err = 1'b0;
    link_bus_wake  = 1'b0;
    tick();
    tick();
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking testbench for the event capture and wake flagging block.
`timescale 1ns/10ps
module testbench;
  import ecwf_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int  DLY_N = 4;       // Short event delay keeps runs brief.
  localparam time LIMIT = 200000;  // Watchdog span in ns.
  logic       clk_sys = 1'b0;
  logic       reset, reg_wr, reg_rd, serial_fault_evt, por_evt;
  logic       uv_forced_sleep, mode_cmd_valid, mode_is_sleep;
  logic       mode_is_normal, trx_active, trx_offline, wake_pin;
  logic       overtemp_pin, txd_clamp_pin, vcc_uv_pin, bus_activity_pin;
  logic       clk_link, link_bus_wake, link_frame_err, rxd_out;
  logic       supply_enable_output, wake_to_standby;
  logic       sleep_grant, sleep_refused;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] mode_command_field;
  logic [1:0] bus_mode_control_field;
  int         mismatches = 0, samples_checked = 0, stb_seen = 0;
  logic [6:0] addrs [8] = '{ADDR_SYS_EN, ADDR_TRX_EN, ADDR_WAKE_EN,
    ADDR_SUMMARY, ADDR_SYS_FLAGS, ADDR_TRX_FLAGS, ADDR_WAKE_FLAGS, 7'h10};

  always #2.5 clk_sys = ~clk_sys;

  ecwf_event_capture #(
    .EVENT_DELAY_CYC(24'h000004),
    .SILENCE_CYC    (24'h000014)
  ) ecwf_event_capture_i (
    .clk_sys(clk_sys), .reset(reset), .clk_link(clk_link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_fault_evt(serial_fault_evt), .por_evt(por_evt),
    .uv_forced_sleep(uv_forced_sleep), .mode_cmd_valid(mode_cmd_valid),
    .mode_command_field(mode_command_field),
    .mode_is_sleep(mode_is_sleep), .mode_is_normal(mode_is_normal),
    .trx_active(trx_active), .trx_offline(trx_offline),
    .bus_mode_control_field(bus_mode_control_field),
    .wake_pin(wake_pin), .overtemp_pin(overtemp_pin),
    .txd_clamp_pin(txd_clamp_pin), .vcc_uv_pin(vcc_uv_pin),
    .bus_activity_pin(bus_activity_pin), .link_bus_wake(link_bus_wake),
    .link_frame_err(link_frame_err), .rxd_out(rxd_out),
    .supply_enable_output(supply_enable_output),
    .wake_to_standby(wake_to_standby), .sleep_grant(sleep_grant),
    .sleep_refused(sleep_refused));

  ecwf_link_model link_i (
    .clk_link(clk_link), .link_bus_wake(link_bus_wake),
    .link_frame_err(link_frame_err));

  // Counts wake pulses; a one-cycle pulse is easy to miss by polling.
  // Sampled on the falling edge, where the pulse has settled.
  always @(negedge clk_sys) begin
    if (wake_to_standby === 1'b1) begin
      stb_seen++;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Waits n edges, then steps just past the edge to drive or sample.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Strobes drop at their sampling edge, so a following call can raise
  // them again one step later without two changes in one time step.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Event pulse: 0 serial fault, 1 battery restore, 2 undervoltage.
  task automatic ev(input int k);
    {uv_forced_sleep, por_evt, serial_fault_evt} = 3'b001 << k;
    @(posedge clk_sys);
    {uv_forced_sleep, por_evt, serial_fault_evt} <= 3'b000;
    #1;
  endtask

  task automatic cmd(input logic [7:0] exp);
    mode_cmd_valid = 1'b1;
    @(posedge clk_sys);
    mode_cmd_valid <= 1'b0;
    #1;
    chk({6'h00, sleep_grant, sleep_refused}, exp);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #LIMIT;
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, serial_fault_evt, por_evt, uv_forced_sleep} = '0;
    {mode_cmd_valid, mode_is_sleep, mode_is_normal, trx_active} = '0;
    {wake_pin, overtemp_pin, txd_clamp_pin, vcc_uv_pin} = '0;
    bus_activity_pin = 1'b0;
    trx_offline = 1'b1;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    mode_command_field = MODE_SLEEP_CMD;
    bus_mode_control_field = 2'h0;
    // Reset is held long enough for the link clock to clear its side.
    repeat (5) link_i.tick();
    cyc(1);
    reset = 1'b0;
    // Flush the link reset stages before the first frame arrives.
    repeat (3) link_i.tick();
    foreach (addrs[i]) rdc(addrs[i], 8'h00);
    wr(ADDR_SYS_EN, 8'hFF);
    wr(ADDR_TRX_EN, 8'hEF);
    wr(ADDR_WAKE_EN, 8'hFF);
    wr(ADDR_SUMMARY, 8'hFF);
    rdc(ADDR_SYS_EN, 8'h06);
    rdc(ADDR_TRX_EN, 8'h03);
    rdc(ADDR_WAKE_EN, 8'h03);
    rdc(ADDR_SUMMARY, 8'h00);
    wr(ADDR_SYS_EN, 8'h00);
    wr(ADDR_TRX_EN, 8'h00);
    wr(ADDR_WAKE_EN, 8'h00);
    ev(0);
    rdc(ADDR_SYS_FLAGS, 8'h00);
    ev(1);
    rdc(ADDR_SYS_FLAGS, 8'h10);
    rdc(ADDR_SUMMARY, 8'h01);
    chk({7'h00, rxd_out}, 8'h00);
    wr(ADDR_SYS_EN, 8'h02);
    ev(0);
    rdc(ADDR_SYS_FLAGS, 8'h12);
    wr(ADDR_SYS_FLAGS, 8'h00);
    rdc(ADDR_SYS_FLAGS, 8'h12);
    wr(ADDR_SYS_FLAGS, 8'h02);
    chk({7'h00, rxd_out}, 8'h01);
    ev(0);
    rdc(ADDR_SYS_FLAGS, 8'h12);
    chk({7'h00, rxd_out}, 8'h01);
    cyc(DLY_N);
    chk({7'h00, rxd_out}, 8'h00);
    wr(ADDR_SYS_FLAGS, 8'h12);
    cyc(DLY_N + 4);
    chk({7'h00, rxd_out}, 8'h01);
    // Both wake pin edges pass the synchroniser before being read.
    wr(ADDR_WAKE_EN, 8'h03);
    wake_pin = 1'b1;
    cyc(6);
    rdc(ADDR_WAKE_FLAGS, 8'h02);
    wake_pin = 1'b0;
    cyc(6);
    rdc(ADDR_WAKE_FLAGS, 8'h03);
    rdc(ADDR_SUMMARY, 8'h08);
    wr(ADDR_WAKE_FLAGS, 8'h03);
    wr(ADDR_WAKE_EN, 8'h00);
    wr(ADDR_TRX_EN, 8'h01);
    link_i.send(1'b0);
    link_i.send(1'b1);
    cyc(6);
    rdc(ADDR_TRX_FLAGS, 8'h21);
    rdc(ADDR_SUMMARY, 8'h04);
    wr(ADDR_TRX_FLAGS, 8'h21);
    wr(ADDR_TRX_EN, 8'h10);
    bus_activity_pin = 1'b1;
    cyc(40);
    rdc(ADDR_TRX_FLAGS, 8'h10);
    wr(ADDR_TRX_FLAGS, 8'h10);
    // Failure and overtemperature are refused outside Normal mode.
    wr(ADDR_TRX_EN, 8'h02);
    wr(ADDR_SYS_EN, 8'h04);
    {trx_offline, trx_active, txd_clamp_pin, overtemp_pin} = 4'b0111;
    cyc(6);
    rdc(ADDR_TRX_FLAGS, 8'h00);
    rdc(ADDR_SYS_FLAGS, 8'h00);
    {mode_is_normal, txd_clamp_pin, overtemp_pin} = 3'b100;
    cyc(6);
    {txd_clamp_pin, overtemp_pin} = 2'b11;
    cyc(6);
    rdc(ADDR_TRX_FLAGS, 8'h02);
    rdc(ADDR_SYS_FLAGS, 8'h04);
    // Supply undervoltage raises a failure only with the check code.
    wr(ADDR_TRX_FLAGS, 8'h02);
    vcc_uv_pin = 1'b1;
    cyc(6);
    rdc(ADDR_TRX_FLAGS, 8'h00);
    {bus_mode_control_field, vcc_uv_pin} = {CMC_UV_CHECK, 1'b0};
    cyc(6);
    vcc_uv_pin = 1'b1;
    cyc(6);
    rdc(ADDR_TRX_FLAGS, 8'h02);
    vcc_uv_pin = 1'b0;
    {txd_clamp_pin, overtemp_pin, mode_is_normal, trx_active} = '0;
    trx_offline = 1'b1;
    cyc(6);
    wr(ADDR_TRX_FLAGS, 8'h02);
    wr(ADDR_SYS_FLAGS, 8'h04);
    wr(ADDR_TRX_EN, 8'h00);
    // A mode code other than go-to-sleep gets neither answer.
    mode_command_field = 3'h2;
    cmd(8'h00);
    mode_command_field = MODE_SLEEP_CMD;
    cmd(8'h01);
    ev(1);
    wr(ADDR_WAKE_EN, 8'h02);
    cmd(8'h01);
    wr(ADDR_SYS_FLAGS, 8'h10);
    cmd(8'h02);
    chk({7'h00, supply_enable_output}, 8'h00);
    mode_is_sleep = 1'b1;
    wake_pin = 1'b1;
    cyc(6);
    chk({7'h00, supply_enable_output}, 8'h01);
    chk(8'(stb_seen), 8'h01);
    mode_is_sleep = 1'b0;
    ev(1);
    rdc(ADDR_SYS_FLAGS, 8'h10);
    ev(2);
    rdc(ADDR_SYS_FLAGS, 8'h00);
    rdc(ADDR_WAKE_FLAGS, 8'h00);
    rdc(ADDR_WAKE_EN, 8'h03);
    print_verdict();
  end
endmodule
